// ### logic/ots_defs.svh
// register offsets, reset values and timing constants of the output selector
`ifndef OTS_DEFS_SVH
`define OTS_DEFS_SVH

`define OTS_ADR_MODE 8'h00
`define OTS_ADR_FN0 8'h04
`define OTS_ADR_FN1 8'h08
`define OTS_ADR_FN2 8'h0c
`define OTS_ADR_FN3 8'h10
`define OTS_ADR_FN4 8'h14
`define OTS_ADR_COMM 8'h18
`define OTS_ADR_SETCNT 8'h1c
`define OTS_ADR_DESCNT 8'h20
`define OTS_ADR_TGTLEN 8'h24
`define OTS_ADR_RUNTHR 8'h28
`define OTS_ADR_PONTHR 8'h2c
`define OTS_ADR_STATUS 8'h30

`define OTS_RST_MODE 1'h0
`define OTS_RST_FN0 16'h0000
`define OTS_RST_FN1 16'h0002
`define OTS_RST_FN2 16'h0000
`define OTS_RST_FN3 16'h0001
`define OTS_RST_FN4 16'h0004

`define OTS_CODE_COMM 16'h0014
`define OTS_CODE_LIMIT 16'h001d

`define OTS_CLK_HZ 100000000
`define OTS_PULSE_FMAX_HZ 100000
`define OTS_PULSE_MIN_HALF (`OTS_CLK_HZ / (2 * `OTS_PULSE_FMAX_HZ))
`define OTS_OL_LEAD_MS 16'h2710
`define OTS_PLC_PULSE_MS 250
`define OTS_PLC_CYCLES (`OTS_PLC_PULSE_MS * (`OTS_CLK_HZ / 1000))

`endif

// ### logic/ots_pkg.sv
// types shared by the output terminal function selector
package ots_pkg;

  typedef enum logic [4:0] {
    OTS_TERM_SWITCH = 5'h01,
    OTS_TERM_BOARD_RELAY = 5'h02,
    OTS_TERM_CARD_RELAY = 5'h04,
    OTS_TERM_COLLECTOR = 5'h08,
    OTS_TERM_CARD_DO = 5'h10
  } ots_term_e;

  typedef struct packed {
    logic running;
    logic fault_stop;
    logic fdt_level;
    logic freq_reached;
    logic zero_freq;
    logic motor_ol_warn;
    logic speed_mode;
    logic torque_limit;
    logic stall;
    logic ready;
    logic set_out_of_limit;
    logic at_upper;
    logic at_lower;
    logic undervoltage;
    logic plc_done;
    logic freq_level;
    logic freq1;
    logic freq2;
    logic current1;
  } ots_cond_s;

  typedef struct packed {
    logic [15:0] ol_trip_ms;
    logic [15:0] count_value;
    logic [15:0] actual_length;
    logic [15:0] run_time;
    logic [15:0] power_on_time;
    logic [15:0] analog_input_first;
    logic [15:0] analog_input_second;
    logic [15:0] pulse_half_period;
  } ots_meas_s;

  typedef struct packed {
    logic mode;
    logic [4:0][15:0] fn;
    logic [4:0] comm;
    logic [15:0] set_count;
    logic [15:0] designated_count;
    logic [15:0] target_length;
    logic [15:0] run_thr;
    logic [15:0] pon_thr;
    logic [4:0] term;
    logic mux_out;
    logic [15:0] pulse_cnt;
    logic pulse_lvl;
    logic [31:0] plc_cnt;
    logic ack;
    logic [31:0] rdata;
  } ots_state_s;

endpackage : ots_pkg

// ### logic/ots_top.sv
// output terminal function selector with wishbone register access
`timescale 1ns/1ps
`default_nettype none
`include "ots_defs.svh"

module ots_top
  import ots_pkg::*;
#(
  parameter int unsigned PLC_CYCLES = `OTS_PLC_CYCLES
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ots_cond_s cond_i,
  input wire ots_meas_s meas_i,
  output logic multiplexed_output_o,
  output logic board_relay_o,
  output logic card_relay_o,
  output logic collector_output_o,
  output logic card_digital_output_o
);

  localparam logic [15:0] MIN_HALF = 16'(`OTS_PULSE_MIN_HALF);
  localparam logic [31:0] PLC_LOAD = 32'(PLC_CYCLES);

  ots_state_s q;
  ots_state_s next_q;
  logic [31:0] cond_vec;
  logic [4:0] sel;
  logic req;
  logic [15:0] half;

  // merge the two low byte lanes into a 16-bit register
  function automatic logic [15:0] ots_wr16(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0])
      r[7:0] = dat[7:0];
    if (be[1])
      r[15:8] = dat[15:8];
    return r;
  endfunction : ots_wr16

  // condition seen by each function code
  always_comb
  begin
    cond_vec = 32'h0000_0000;
    cond_vec[1] = cond_i.running;
    cond_vec[2] = cond_i.fault_stop;
    cond_vec[3] = cond_i.fdt_level;
    cond_vec[4] = cond_i.freq_reached;
    cond_vec[5] = cond_i.running & cond_i.zero_freq;
    cond_vec[6] = cond_i.motor_ol_warn;
    // trip time 16'hffff means no overload building up
    cond_vec[7] = meas_i.ol_trip_ms <= `OTS_OL_LEAD_MS;
    cond_vec[8] = meas_i.count_value >= q.set_count;
    cond_vec[9] = meas_i.count_value >= q.designated_count;
    cond_vec[10] = meas_i.actual_length > q.target_length;
    cond_vec[11] = q.plc_cnt != 32'h0000_0000;
    cond_vec[12] = meas_i.run_time > q.run_thr;
    cond_vec[13] = cond_i.set_out_of_limit
                   & (cond_i.at_upper | cond_i.at_lower);
    cond_vec[14] = cond_i.speed_mode & cond_i.torque_limit
                   & cond_i.stall;
    cond_vec[15] = cond_i.ready;
    cond_vec[16] = meas_i.analog_input_first
                   > meas_i.analog_input_second;
    cond_vec[17] = cond_i.at_upper;
    cond_vec[18] = cond_i.running & cond_i.at_lower;
    cond_vec[19] = cond_i.undervoltage;
    cond_vec[23] = cond_i.zero_freq | ~cond_i.running;
    cond_vec[24] = meas_i.power_on_time > q.pon_thr;
    cond_vec[25] = cond_i.freq_level;
    cond_vec[26] = cond_i.freq1;
    cond_vec[27] = cond_i.freq2;
    cond_vec[28] = cond_i.current1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_term
      always_comb
      begin
        if (q.fn[gi] == `OTS_CODE_COMM)
          sel[gi] = q.comm[gi];
        else if (q.fn[gi] < `OTS_CODE_LIMIT)
          sel[gi] = cond_vec[q.fn[gi][4:0]];
        else
          sel[gi] = 1'b0;
      end
    end
  endgenerate

  assign req = wb_cyc_i & wb_stb_i & ~q.ack;
  // never toggle faster than the 100 kHz ceiling allows
  assign half = (meas_i.pulse_half_period < MIN_HALF) ?
                MIN_HALF : meas_i.pulse_half_period;

  always_comb
  begin
    next_q = q;
    next_q.ack = req;
    // pulse train generator, idle low in switch mode or at zero rate
    if (q.mode == 1'b0 && meas_i.pulse_half_period != 16'h0000)
    begin
      if (q.pulse_cnt >= half - 16'h0001)
      begin
        next_q.pulse_cnt = 16'h0000;
        next_q.pulse_lvl = ~q.pulse_lvl;
      end
      else
        next_q.pulse_cnt = q.pulse_cnt + 16'h0001;
    end
    else
    begin
      next_q.pulse_cnt = 16'h0000;
      next_q.pulse_lvl = 1'b0;
    end
    // a new cycle end restarts the pulse rather than extending it
    if (cond_i.plc_done)
      next_q.plc_cnt = PLC_LOAD;
    else if (q.plc_cnt != 32'h0000_0000)
      next_q.plc_cnt = q.plc_cnt - 32'h0000_0001;
    next_q.term = sel;
    if (q.mode)
      next_q.mux_out = sel[0];
    else
      next_q.mux_out = q.pulse_lvl;
    // register writes
    if (req && wb_we_i)
    begin
      if (wb_adr_i == `OTS_ADR_MODE)
      begin
        if (wb_sel_i[0])
          next_q.mode = wb_dat_i[0];
      end
      else if (wb_adr_i == `OTS_ADR_FN0)
        next_q.fn[0] = ots_wr16(q.fn[0], wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OTS_ADR_FN1)
        next_q.fn[1] = ots_wr16(q.fn[1], wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OTS_ADR_FN2)
        next_q.fn[2] = ots_wr16(q.fn[2], wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OTS_ADR_FN3)
        next_q.fn[3] = ots_wr16(q.fn[3], wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OTS_ADR_FN4)
        next_q.fn[4] = ots_wr16(q.fn[4], wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OTS_ADR_COMM)
      begin
        if (wb_sel_i[0])
          next_q.comm = wb_dat_i[4:0];
      end
      else if (wb_adr_i == `OTS_ADR_SETCNT)
        next_q.set_count = ots_wr16(q.set_count, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OTS_ADR_DESCNT)
        next_q.designated_count =
          ots_wr16(q.designated_count, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OTS_ADR_TGTLEN)
        next_q.target_length =
          ots_wr16(q.target_length, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OTS_ADR_RUNTHR)
        next_q.run_thr = ots_wr16(q.run_thr, wb_dat_i, wb_sel_i);
      else if (wb_adr_i == `OTS_ADR_PONTHR)
        next_q.pon_thr = ots_wr16(q.pon_thr, wb_dat_i, wb_sel_i);
    end
    // register reads; unmapped addresses answer zero
    next_q.rdata = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      if (wb_adr_i == `OTS_ADR_MODE)
        next_q.rdata = {31'h0000_0000, q.mode};
      else if (wb_adr_i == `OTS_ADR_FN0)
        next_q.rdata = {16'h0000, q.fn[0]};
      else if (wb_adr_i == `OTS_ADR_FN1)
        next_q.rdata = {16'h0000, q.fn[1]};
      else if (wb_adr_i == `OTS_ADR_FN2)
        next_q.rdata = {16'h0000, q.fn[2]};
      else if (wb_adr_i == `OTS_ADR_FN3)
        next_q.rdata = {16'h0000, q.fn[3]};
      else if (wb_adr_i == `OTS_ADR_FN4)
        next_q.rdata = {16'h0000, q.fn[4]};
      else if (wb_adr_i == `OTS_ADR_COMM)
        next_q.rdata = {27'h000_0000, q.comm};
      else if (wb_adr_i == `OTS_ADR_SETCNT)
        next_q.rdata = {16'h0000, q.set_count};
      else if (wb_adr_i == `OTS_ADR_DESCNT)
        next_q.rdata = {16'h0000, q.designated_count};
      else if (wb_adr_i == `OTS_ADR_TGTLEN)
        next_q.rdata = {16'h0000, q.target_length};
      else if (wb_adr_i == `OTS_ADR_RUNTHR)
        next_q.rdata = {16'h0000, q.run_thr};
      else if (wb_adr_i == `OTS_ADR_PONTHR)
        next_q.rdata = {16'h0000, q.pon_thr};
      else if (wb_adr_i == `OTS_ADR_STATUS)
        next_q.rdata = {26'h000_0000, q.mux_out, q.term};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      q <= '0;
      q.mode <= `OTS_RST_MODE;
      q.fn[0] <= `OTS_RST_FN0;
      q.fn[1] <= `OTS_RST_FN1;
      q.fn[2] <= `OTS_RST_FN2;
      q.fn[3] <= `OTS_RST_FN3;
      q.fn[4] <= `OTS_RST_FN4;
    end
    else
      q <= next_q;
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign multiplexed_output_o = q.mux_out;
  assign board_relay_o = q.term[1];
  assign card_relay_o = q.term[2];
  assign collector_output_o = q.term[3];
  assign card_digital_output_o = q.term[4];

endmodule : ots_top
`default_nettype wire

// ### tb/ots_top_monitor.sv
// port checker of the output terminal selector, bound into ots_top
`timescale 1ns/1ps
`default_nettype none
`include "ots_defs.svh"
module ots_top_monitor
  import ots_pkg::*;
#(
  parameter int unsigned PLC_CYCLES = 20
)
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ots_cond_s cond_i,
  input wire logic board_relay_o,
  input wire logic card_relay_o,
  input wire logic collector_output_o,
  input wire logic card_digital_output_o
);
  // shadow of codes 1..4, taken at the edge that samples the write ack, one cycle after the registers
  logic [4:1][15:0] fn;
  logic [1:0] quiet;
  ots_cond_s c1, c2;
  logic calm, fn_wr;
  // quiet bus and flags steady two cycles hide the output latency
  assign calm = quiet == 2'h3 && cond_i == c1 && c1 == c2;
  assign fn_wr = wb_ack_o && wb_we_i && wb_adr_i >= `OTS_ADR_FN1
    && wb_adr_i <= `OTS_ADR_FN4 && wb_adr_i[1:0] == 2'h0;
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      fn <= {`OTS_RST_FN4, `OTS_RST_FN3, `OTS_RST_FN2, `OTS_RST_FN1};
      quiet <= 2'h0;
      c1 <= '0;
      c2 <= '0;
    end
    else
    begin
      if (fn_wr)
        fn[wb_adr_i[4:2] - 3'h1] <= wb_dat_i[15:0];
      quiet <= (wb_ack_o && wb_we_i) ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
      c1 <= cond_i;
      c2 <= c1;
    end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  AST_ACK_TAKE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not acked");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_CODE_ZERO: assert property (calm && fn[2] == 16'h0 |-> !card_relay_o)
    else $error("code 0 terminal on");
  AST_RUN: assert property (calm && fn[3] == 16'h1 |->
    collector_output_o == cond_i.running) else $error("code 1 wrong");
  AST_FAULT: assert property (calm && fn[1] == 16'h2 |->
    board_relay_o == cond_i.fault_stop) else $error("code 2 wrong");
  AST_ZERO_RUN: assert property (calm && fn[1] == 16'h5 |->
    board_relay_o == (cond_i.running && cond_i.zero_freq))
    else $error("code 5 wrong");
  AST_PASS: assert property (calm && fn[4] == 16'h4 |->
    card_digital_output_o == cond_i.freq_reached) else $error("code 4 wrong");
  AST_RESERVED: assert property (calm && (fn[1] == 16'h15
    || fn[1] == 16'h16 || fn[1] >= `OTS_CODE_LIMIT) |-> !board_relay_o)
    else $error("unused code terminal on");
  COV_WRITE: cover property (wb_ack_o && wb_we_i);
  COV_ZERO_RUN: cover property (calm && fn[1] == 16'h5 && board_relay_o);
  COV_RELAY: cover property ($rose(board_relay_o));
endmodule : ots_top_monitor
bind ots_top ots_top_monitor #(.PLC_CYCLES(PLC_CYCLES)) u_ots_top_monitor (.*);
`default_nettype wire

// ### tb/ots_load_model.sv
// load or pulse receiver on one terminal, records high and low widths
`timescale 1ns/1ps
`default_nettype none
module ots_load_model
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic pin_i,
  output logic [31:0] high_width_o,
  output logic [31:0] low_width_o
);
  logic prev;
  logic [31:0] run;
  // widths in whole clock cycles between level changes
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      prev <= 1'b0;
      run <= 32'h0;
      high_width_o <= 32'h0;
      low_width_o <= 32'h0;
    end
    else if (pin_i != prev)
    begin
      if (prev)
        high_width_o <= run;
      else
        low_width_o <= run;
      prev <= pin_i;
      run <= 32'h1;
    end
    else
      run <= run + 32'h1;
endmodule : ots_load_model
`default_nettype wire

// ### tb/ots_top_tb_top.sv
// self-checking bench of the output terminal selector
`timescale 1ns/1ps
`default_nettype none
`include "ots_defs.svh"
module ots_top_tb_top
  import ots_pkg::*;
;
  localparam int unsigned PLC = 20;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  ots_cond_s cond = '0;
  ots_meas_s meas = '0;
  logic ack, mux, brel, crel, coll, cdo;
  logic [31:0] rdat, hw0, lw0, hw1, rd;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] dflt [6] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h1, 32'h4};
  logic [31:0] thr [5] = '{32'h5, 32'h7, 32'ha, 32'h14, 32'h1e};
  logic [15:0] t_code [26] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5,
    16'h5, 16'h6, 16'hd, 16'hd, 16'he, 16'he, 16'hf, 16'h11, 16'h12, 16'h12,
    16'h13, 16'h15, 16'h16, 16'h17, 16'h17, 16'h19, 16'h1a, 16'h1b, 16'h1c,
    16'h1d};
  // flags in struct order, running is the top bit
  logic [18:0] t_cond [26] = '{19'h7ffff, 19'h40000, 19'h20000, 19'h10000,
    19'h08000, 19'h44000, 19'h04000, 19'h02000, 19'h00180, 19'h00080,
    19'h01c00, 19'h01800, 19'h00200, 19'h00080, 19'h40040, 19'h00040,
    19'h00020, 19'h7ffff, 19'h7ffff, 19'h0, 19'h40000, 19'h00008, 19'h00004,
    19'h00002, 19'h00001, 19'h7ffff};
  logic [25:0] t_exp = 26'h1e975be;
  logic [15:0] m_code [7] = '{16'h7, 16'h8, 16'h9, 16'ha, 16'hc, 16'h10,
    16'h18};
  logic [6:0] m_exp = 7'h7b;

  always #5 ref_clk = ~ref_clk;

  ots_top #(.PLC_CYCLES(PLC)) u_ots_top (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cond_i(cond), .meas_i(meas), .multiplexed_output_o(mux),
    .board_relay_o(brel), .card_relay_o(crel), .collector_output_o(coll),
    .card_digital_output_o(cdo));
  ots_load_model u_ots_load_model (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .pin_i(mux), .high_width_o(hw0), .low_width_o(lw0));
  ots_load_model u_ots_load_model_b (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .pin_i(brel), .high_width_o(hw1), .low_width_o());

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk

  // classic cycle: request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
      @(posedge ref_clk);
    while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk($sformatf("read %h", a), exp, rd);
  endtask : rdc

  task automatic settle(input ots_cond_s c);
    @(posedge ref_clk);
    cond <= c;
    repeat (3) @(posedge ref_clk);
  endtask : settle

  task automatic tcode(input logic [15:0] code, input ots_cond_s c,
    input logic exp);
    wb(1'b1, `OTS_ADR_FN1, {16'h0, code});
    settle(c);
    chk($sformatf("code %h", code), {31'h0, exp}, {31'h0, brel});
  endtask : tcode

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      results();
    end
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 6; i++)
      rdc(8'(4 * i), dflt[i]);
    wb(1'b1, 8'hfc, 32'hffff);
    rdc(8'hfc, 32'h0);
    wb(1'b1, `OTS_ADR_FN2, 32'hffff001b);
    rdc(`OTS_ADR_FN2, 32'h1b);
    wb(1'b1, `OTS_ADR_FN2, 32'h0);
    settle(19'h40000);
    chk("collector", 32'h1, {31'h0, coll});
    chk("card relay", 32'h0, {31'h0, crel});
    settle(19'h28000);
    chk("card output", 32'h1, {31'h0, cdo});
    for (int i = 0; i < 13; i++)
      tcode(t_code[i], t_cond[i], t_exp[i]);
    for (int i = 13; i < 26; i++)
      tcode(t_code[i], t_cond[i], t_exp[i]);
    wb(1'b1, `OTS_ADR_COMM, 32'h2);
    tcode(16'h14, 19'h0, 1'b1);
    wb(1'b1, `OTS_ADR_COMM, 32'h1d);
    tcode(16'h14, 19'h0, 1'b0);
    for (int i = 0; i < 5; i++)
      wb(1'b1, `OTS_ADR_SETCNT + 8'(4 * i), thr[i]);
    meas <= {16'h2711, 16'h4, 16'ha, 16'h14, 16'h1e, 16'h1, 16'h1, 16'h0};
    for (int i = 0; i < 7; i++)
      tcode(m_code[i], 19'h0, 1'b0);
    meas <= {16'h2710, 16'h5, 16'hb, 16'h15, 16'h1f, 16'h2, 16'h1, 16'h0};
    for (int i = 0; i < 7; i++)
      tcode(m_code[i], 19'h0, m_exp[i]);
    meas.count_value <= 16'h7;
    tcode(16'h9, 19'h0, 1'b1);
    wb(1'b1, `OTS_ADR_FN1, 32'hb);
    @(posedge ref_clk);
    cond <= 19'h10;
    @(posedge ref_clk);
    cond <= 19'h0;
    repeat (PLC + 10) @(posedge ref_clk);
    chk("sequence pulse", PLC, hw1);
    meas.pulse_half_period <= 16'h258;
    // long enough for one full low phase after the first high phase
    repeat (2000) @(posedge ref_clk);
    chk("pulse high", 32'h258, hw0);
    chk("pulse low", 32'h258, lw0);
    meas.pulse_half_period <= 16'h64;
    repeat (1600) @(posedge ref_clk);
    chk("clamped pulse", 32'h1f4, hw0);
    chk("clamped low", 32'h1f4, lw0);
    wb(1'b1, `OTS_ADR_FN0, 32'h1);
    wb(1'b1, `OTS_ADR_MODE, 32'h1);
    settle(19'h40000);
    chk("switch terminal", 32'h1, {31'h0, mux});
    rdc(`OTS_ADR_STATUS, 32'h29);
    settle(19'h0);
    chk("switch terminal", 32'h0, {31'h0, mux});
    results();
  end
endmodule : ots_top_tb_top
`default_nettype wire
